// ---- hw/frc_regs.sv ----
// Flash rewrite control and status registers with small operation tracker.
// Assumes a byte register port with one-cycle strobes and an external sequencer
// that reports command start, end and error.
//
// Operation
// - Stop bit blocks all flash array access
// - Stop in rewrite mode resets, powers down
// - Stop outside rewrite mode blocks array, no reset
// - Program error flag read-only, shows result
// - Erase error flag read-only, shows result
// - Clear status command clears both errors
// - Mode select picks in-place or RAM mode
// - Block 0 needs enable and unlocked
// - Block 1 needs enable and unlocked
// - Suspend enable gates all suspends
// - RAM mode erase suspend by software
// - In-place mode interrupt sets erase suspend
// - RAM mode program suspend by software
// - In-place mode interrupt sets program suspend
// - Erase active flag spans whole erase
// - Program active flag spans whole program
// - Read allowed zero while busy, one suspended
// - Low power read enable cuts read power
// - Ready flag low while busy, resets ready
// - Rewrite disable clears low blocks enable
// - Rewrite disable clears select and locks
// - Locks writable only in rewrite mode
// - Low blocks disabled rejects blocks 0,1
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps

module frc_regs
	import frc_pkg::*;
(
	input  wire logic        CLK,       // System clock, 200 MHz
	input  wire logic        RST,       // Asynchronous reset, active high
	input  wire logic [15:0] ADDR,      // Register address
	input  wire logic [7:0]  WDATA,     // Write data
	input  wire logic        WR,        // Write strobe
	input  wire logic        RD,        // Read strobe
	output logic      [7:0]  RDATA,     // Read data, cycle after RD
	input  wire frc_seq_t    SEQ,       // Sequencer events
	output logic             CMD_ACCEPT, // Command allowed to start
	output logic             SUSPEND,    // Sequencer must hold
	output logic             ARRAY_EN,   // Flash array accessible
	output logic             FLASH_RESET, // Control circuit reset
	output logic             LOW_POWER,  // Array low power state
	output logic             LP_READ     // Low power read mode
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	frc_state_t s_q;  // Registered state
	frc_state_t s_d;  // Next state
	logic       busy; // Operation in progress
	logic       susp; // Current operation suspended
	logic       blk_ok; // Target block open for rewrite
	logic       start;  // Accepted start
	logic [7:0] main_r; // Main register view
	logic [7:0] lock_r; // Lock register view
	logic [7:0] susp_r; // Suspend register view

	// ----------------------------------------------------------------
	// Combinational views
	// ----------------------------------------------------------------
	always_comb
	begin
		busy   = (s_q.op != FRC_IDLE);
		susp   = (s_q.op == FRC_ERASE && s_q.esr) || (s_q.op == FRC_PROG && s_q.psr);
		// Low blocks need enable and a clear lock
		blk_ok = 1'b1;
		if (SEQ.target_blk0 && !(s_q.lbe && !s_q.lk0))
			blk_ok = 1'b0;
		if (SEQ.target_blk1 && !(s_q.lbe && !s_q.lk1))
			blk_ok = 1'b0;
		CMD_ACCEPT = s_q.rwe && !s_q.stp && !busy && blk_ok;
		start      = CMD_ACCEPT && (SEQ.prog_start || SEQ.erase_start);
		// Register views, reserved bits fixed
		main_r = 8'h00;
		main_r[FRC_M_RDY]  = !busy;
		main_r[FRC_M_RWE]  = s_q.rwe;
		main_r[FRC_M_LBE]  = s_q.lbe;
		main_r[FRC_M_STP]  = s_q.stp;
		main_r[FRC_M_PERR] = s_q.perr;
		main_r[FRC_M_EERR] = s_q.eerr;
		lock_r = FRC_LOCK_FIX;
		lock_r[FRC_L_SEL] = s_q.sel;
		lock_r[FRC_L_B0]  = s_q.lk0;
		lock_r[FRC_L_B1]  = s_q.lk1;
		susp_r = 8'h00;
		susp_r[FRC_S_SEN]  = s_q.sen;
		susp_r[FRC_S_ESR]  = s_q.esr;
		susp_r[FRC_S_PSR]  = s_q.psr;
		susp_r[FRC_S_EACT] = (s_q.op == FRC_ERASE);
		susp_r[FRC_S_PACT] = (s_q.op == FRC_PROG);
		susp_r[FRC_S_RDOK] = !busy || susp;
		susp_r[FRC_S_LPR]  = s_q.lpr;
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		s_d = s_q;
		// Main register write
		if (WR && ADDR == FRC_OFF_MAIN)
		begin
			s_d.rwe = WDATA[FRC_M_RWE];
			s_d.lbe = WDATA[FRC_M_LBE] && WDATA[FRC_M_RWE];
			s_d.stp = WDATA[FRC_M_STP];
		end
		// Lock register write
		if (WR && ADDR == FRC_OFF_LOCK)
		begin
			s_d.sel = WDATA[FRC_L_SEL];
			if (s_q.rwe)
			begin
				s_d.lk0 = WDATA[FRC_L_B0];
				s_d.lk1 = WDATA[FRC_L_B1];
			end
		end
		// Suspend register write
		if (WR && ADDR == FRC_OFF_SUSP)
		begin
			s_d.sen = WDATA[FRC_S_SEN];
			s_d.lpr = WDATA[FRC_S_LPR];
			// Zero always resumes; one only from software in RAM mode
			if (!WDATA[FRC_S_ESR] || (!s_q.sel && s_q.sen && s_q.op == FRC_ERASE))
				s_d.esr = WDATA[FRC_S_ESR];
			if (!WDATA[FRC_S_PSR] || (!s_q.sel && s_q.sen && s_q.op == FRC_PROG))
				s_d.psr = WDATA[FRC_S_PSR];
		end
		// In-place mode interrupt suspends
		if (SEQ.irq_req && s_q.sel && s_q.sen)
		begin
			if (s_q.op == FRC_ERASE)
				s_d.esr = 1'b1;
			if (s_q.op == FRC_PROG)
				s_d.psr = 1'b1;
		end
		// Clear status command
		if (SEQ.clear_stat)
		begin
			s_d.perr = 1'b0;
			s_d.eerr = 1'b0;
		end
		// Operation tracking
		if (start)
		begin
			s_d.op = SEQ.erase_start ? FRC_ERASE : FRC_PROG;
			if (SEQ.erase_start)
				s_d.eerr = 1'b0;
			else
				s_d.perr = 1'b0;
		end
		else if (busy && !susp && SEQ.op_done)
		begin
			// Error set wins over a same-cycle clear
			if (s_q.op == FRC_PROG)
				s_d.perr = SEQ.op_error;
			else
				s_d.eerr = SEQ.op_error;
			s_d.op = FRC_IDLE;
		end
		// Requests exist only while their operation runs
		if (s_d.op != FRC_ERASE || !s_d.sen)
			s_d.esr = 1'b0;
		if (s_d.op != FRC_PROG || !s_d.sen)
			s_d.psr = 1'b0;
		// Rewrite disable clears dependents
		if (!s_d.rwe)
		begin
			s_d.lbe = 1'b0;
			s_d.sel = 1'b0;
			s_d.lk0 = 1'b0;
			s_d.lk1 = 1'b0;
		end
		// Stop in rewrite mode resets the operation
		if (s_d.stp && s_d.rwe)
		begin
			s_d.op  = FRC_IDLE;
			s_d.esr = 1'b0;
			s_d.psr = 1'b0;
		end
		// Read data
		s_d.rdata = 8'h00;
		if (RD)
		begin
			unique case (ADDR)
				FRC_OFF_MAIN: s_d.rdata = main_r;
				FRC_OFF_LOCK: s_d.rdata = lock_r;
				FRC_OFF_SUSP: s_d.rdata = susp_r;
				default:      s_d.rdata = 8'h00;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			s_q       <= '0;
			s_q.op    <= FRC_IDLE;
		end
		else
			s_q <= s_d;
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign RDATA       = s_q.rdata;
	assign SUSPEND     = susp;
	assign ARRAY_EN    = !s_q.stp;
	assign FLASH_RESET = s_q.stp && s_q.rwe;
	assign LOW_POWER   = s_q.stp && s_q.rwe;
	assign LP_READ     = s_q.lpr;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_stop_blocks;
		@(posedge CLK) disable iff (RST) s_q.stp |-> !ARRAY_EN;
	endproperty
	a_stop_blocks: assert property (p_stop_blocks) else $error("array open while stopped");

	property p_stop_rst;
		@(posedge CLK) disable iff (RST) (s_q.stp && s_q.rwe) |-> (FLASH_RESET && !busy);
	endproperty
	a_stop_rst: assert property (p_stop_rst) else $error("stop did not reset");

	property p_stop_only;
		@(posedge CLK) disable iff (RST) !s_q.rwe |-> !LOW_POWER;
	endproperty
	a_stop_only: assert property (p_stop_only) else $error("low power without rewrite");

	property p_clr;
		@(posedge CLK) disable iff (RST) (SEQ.clear_stat && !busy) |=> (!s_q.perr && !s_q.eerr);
	endproperty
	a_clr: assert property (p_clr) else $error("clear status failed");

	property p_blk0;
		@(posedge CLK) disable iff (RST) (SEQ.target_blk0 && (!s_q.lbe || s_q.lk0)) |-> !CMD_ACCEPT;
	endproperty
	a_blk0: assert property (p_blk0) else $error("block 0 accepted");

	property p_blk1;
		@(posedge CLK) disable iff (RST) (SEQ.target_blk1 && (!s_q.lbe || s_q.lk1)) |-> !CMD_ACCEPT;
	endproperty
	a_blk1: assert property (p_blk1) else $error("block 1 accepted");

	property p_sen;
		@(posedge CLK) disable iff (RST) !s_q.sen |-> (!s_q.esr && !s_q.psr);
	endproperty
	a_sen: assert property (p_sen) else $error("suspend without enable");

	property p_irq_erase;
		@(posedge CLK) disable iff (RST)
			(SEQ.irq_req && s_q.sel && s_q.sen && s_q.op == FRC_ERASE && !s_q.stp
			 && !SEQ.op_done && !(WR && ADDR == FRC_OFF_SUSP)
			 && !(WR && ADDR == FRC_OFF_MAIN)) |=> s_q.esr;
	endproperty
	a_irq_erase: assert property (p_irq_erase) else $error("interrupt did not suspend");

	property p_ready;
		@(posedge CLK) disable iff (RST) (RD && ADDR == FRC_OFF_MAIN) |=> (RDATA[FRC_M_RDY] == $past(!busy));
	endproperty
	a_ready: assert property (p_ready) else $error("ready flag wrong");

	property p_rwe_off;
		@(posedge CLK) disable iff (RST) !s_q.rwe |-> (!s_q.lbe && !s_q.sel && !s_q.lk0 && !s_q.lk1);
	endproperty
	a_rwe_off: assert property (p_rwe_off) else $error("dependents not cleared");

	// Checked through the read path, so a broken read mux shows up too
	property p_rdok;
		@(posedge CLK) disable iff (RST)
			(RD && ADDR == FRC_OFF_SUSP && busy && !susp) |=> !RDATA[FRC_S_RDOK];
	endproperty
	a_rdok: assert property (p_rdok) else $error("read allowed while busy");

	// Erase stays active while it is held in suspend
	property p_erase_hold;
		@(posedge CLK) disable iff (RST)
			(s_q.op == FRC_ERASE && s_q.esr && !(WR && ADDR == FRC_OFF_MAIN)) |=> (s_q.op == FRC_ERASE);
	endproperty
	a_erase_hold: assert property (p_erase_hold) else $error("erase flag dropped in suspend");

	// An accepted program start raises the program active state
	property p_prog_start;
		@(posedge CLK) disable iff (RST)
			(start && !SEQ.erase_start && !(WR && ADDR == FRC_OFF_MAIN)) |=> (s_q.op == FRC_PROG);
	endproperty
	a_prog_start: assert property (p_prog_start) else $error("program flag not set");

	c_erase: cover property (@(posedge CLK) disable iff (RST) start && SEQ.erase_start);
	c_susp:  cover property (@(posedge CLK) disable iff (RST) susp ##1 !susp);
	c_err:   cover property (@(posedge CLK) disable iff (RST) busy && SEQ.op_done && SEQ.op_error);
endmodule // frc_regs

// ---- inc/frc_pkg.sv ----
// Package for the flash rewrite control register block.
// Assumes a plain byte register port and an external flash sequencer.
package frc_pkg;
	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [15:0] FRC_OFF_SUSP = 16'h01B3; // Suspend control
	localparam logic [15:0] FRC_OFF_LOCK = 16'h01B5; // Block lock and mode
	localparam logic [15:0] FRC_OFF_MAIN = 16'h01B7; // Main control and status
	// ----------------------------------------------------------------
	// Main register field positions
	// ----------------------------------------------------------------
	localparam int FRC_M_RDY  = 0; // Ready flag
	localparam int FRC_M_RWE  = 1; // Rewrite mode enable
	localparam int FRC_M_LBE  = 2; // Low blocks rewrite enable
	localparam int FRC_M_STP  = 3; // Flash stop bit
	localparam int FRC_M_PERR = 6; // Program error flag
	localparam int FRC_M_EERR = 7; // Erase error flag
	// ----------------------------------------------------------------
	// Lock register field positions
	// ----------------------------------------------------------------
	localparam int FRC_L_SEL  = 1; // Rewrite mode select
	localparam int FRC_L_B0   = 5; // Block zero write lock
	localparam int FRC_L_B1   = 6; // Block one write lock
	localparam int FRC_L_FIX1 = 7; // Fixed one
	// ----------------------------------------------------------------
	// Suspend register field positions
	// ----------------------------------------------------------------
	localparam int FRC_S_SEN  = 0; // Suspend enable
	localparam int FRC_S_ESR  = 1; // Erase suspend request
	localparam int FRC_S_PSR  = 2; // Program suspend request
	localparam int FRC_S_EACT = 3; // Erase active flag
	localparam int FRC_S_PACT = 4; // Program active flag
	localparam int FRC_S_RDOK = 6; // Read allowed flag
	localparam int FRC_S_LPR  = 7; // Low power read enable
	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] FRC_RST_MAIN = 8'h01; // Ready after reset
	localparam logic [7:0] FRC_LOCK_FIX = 8'h80; // Fixed bits of lock register
	localparam logic [7:0] FRC_SUSP_RST = 8'h40; // Read allowed after reset
	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		FRC_IDLE  = 2'b00, // No operation
		FRC_PROG  = 2'b01, // Auto-program running or suspended
		FRC_ERASE = 2'b10  // Auto-erase running or suspended
	} frc_op_t;

	// Sequencer events from the flash core
	typedef struct packed {
		logic       prog_start;  // Program command issued
		logic       erase_start; // Block erase command issued
		logic       target_blk1; // Command targets block 1
		logic       target_blk0; // Command targets block 0
		logic       op_done;     // Operation ended
		logic       op_error;    // Operation ended in error
		logic       clear_stat;  // Clear status command
		logic       irq_req;     // Enabled maskable interrupt request
	} frc_seq_t;

	// Whole block state
	typedef struct packed {
		logic       rwe;   // Rewrite mode enable
		logic       lbe;   // Low blocks rewrite enable
		logic       stp;   // Flash stop bit
		logic       perr;  // Program error flag
		logic       eerr;  // Erase error flag
		logic       sel;   // Rewrite mode select
		logic       lk0;   // Block zero write lock
		logic       lk1;   // Block one write lock
		logic       sen;   // Suspend enable
		logic       esr;   // Erase suspend request
		logic       psr;   // Program suspend request
		logic       lpr;   // Low power read enable
		frc_op_t    op;    // Operation in progress
		logic [7:0] rdata; // Read data register
	} frc_state_t;
endpackage

// ---- testbench/flash_rewrite_control_regs_bench.sv ----
// Self-checking bench for the flash rewrite control registers.
// Assumes frc_pkg, frc_regs and frc_seq_model are compiled first.
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin bad_count++; \
	$display("CHECK FAILED %s expected %h seen %h", n, e, g); end end

module flash_rewrite_control_regs_bench
	import frc_pkg::*;
;
	logic        CLK, RST, WR, RD, CMD_ACCEPT, SUSPEND;
	logic        ARRAY_EN, FLASH_RESET, LOW_POWER, LP_READ;
	logic [15:0] ADDR;
	logic [7:0]  WDATA, RDATA, me;
	frc_seq_t    seq;
	logic [3:0]  ev;
	logic        blk1, err, rd_p;
	logic [4:0]  len;
	logic [7:0]  exp_q[$];
	string       nam_q[$], mn;
	int          bad_count, compares, i, k;

	frc_regs u_frc_regs (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
		.RD(RD), .RDATA(RDATA), .SEQ(seq), .CMD_ACCEPT(CMD_ACCEPT), .SUSPEND(SUSPEND),
		.ARRAY_EN(ARRAY_EN), .FLASH_RESET(FLASH_RESET), .LOW_POWER(LOW_POWER),
		.LP_READ(LP_READ));
	frc_seq_model u_frc_seq_model (.clk(CLK), .rst(RST), .ev(ev), .blk1(blk1),
		.err(err), .len(len), .accept(CMD_ACCEPT), .hold(SUSPEND), .seq(seq));

	initial
	begin
		CLK = 1'b0;
		forever #2.5 CLK = ~CLK;
	end

	// ----------------------------------------------------------------
	// Bus and event tasks
	// ----------------------------------------------------------------
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge CLK);
		ADDR  <= a;
		WDATA <= d;
		WR    <= 1'b1;
		@(posedge CLK);
		WR    <= 1'b0;
	endtask
	// The expected byte waits in the queue for the monitor
	task automatic rd(input logic [15:0] a, input logic [7:0] e, input string n);
		@(posedge CLK);
		ADDR <= a;
		RD   <= 1'b1;
		exp_q.push_back(e);
		nam_q.push_back(n);
		@(posedge CLK);
		RD   <= 1'b0;
	endtask
	task automatic pulse(input logic [3:0] v);
		@(posedge CLK);
		ev <= v;
		@(posedge CLK);
		ev <= 4'h0;
	endtask
	task automatic tgt(input logic b);
		@(posedge CLK);
		blk1 <= b;
		#1;
	endtask
	task automatic wait_done();
		for (i = 0; i < 200 && seq.op_done !== 1'b1; i++)
			@(posedge CLK);
		if (seq.op_done !== 1'b1)
		begin
			bad_count++;
			close_out();
		end
		else
			#1;
	endtask
	task automatic close_out();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Monitor: read data stands in the cycle after the strobe
	always @(posedge CLK)
	begin
		if (rd_p && exp_q.size() > 0)
		begin
			me = exp_q.pop_front();
			mn = nam_q.pop_front();
			`CHK(mn, me, RDATA)
		end
		rd_p <= RD;
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		{RST, WR, RD, blk1, err} = 5'h10;
		{ADDR, WDATA, ev, len} = '0;
		repeat (2) @(posedge CLK);
		RST <= 1'b0;
		void'($urandom(32'h2BB2));
		rd(FRC_OFF_MAIN, 8'h01, "main reset");
		rd(FRC_OFF_LOCK, 8'h80, "lock reset");
		rd(FRC_OFF_SUSP, 8'h40, "susp reset");
		wr(16'h01B4, 8'($urandom));
		rd(16'h01B4, 8'h00, "unmapped");
		$display("test reset done");
		wr(FRC_OFF_MAIN, 8'h00);
		wr(FRC_OFF_MAIN, 8'h02);
		wr(FRC_OFF_MAIN, 8'h36);
		rd(FRC_OFF_MAIN, 8'h07, "main enable");
		wr(FRC_OFF_LOCK, 8'h7F);
		rd(FRC_OFF_LOCK, 8'hE2, "lock set");
		tgt(1'b0);
		`CHK("block 0 locked", 1'b0, CMD_ACCEPT)
		tgt(1'b1);
		`CHK("block 1 locked", 1'b0, CMD_ACCEPT)
		wr(FRC_OFF_LOCK, 8'h20);
		#1;
		`CHK("block 1 open", 1'b1, CMD_ACCEPT)
		tgt(1'b0);
		`CHK("block 0 still locked", 1'b0, CMD_ACCEPT)
		wr(FRC_OFF_LOCK, 8'h00);
		#1;
		`CHK("block 0 open", 1'b1, CMD_ACCEPT)
		wr(FRC_OFF_MAIN, 8'h02);
		#1;
		`CHK("low blocks off", 1'b0, CMD_ACCEPT)
		wr(FRC_OFF_MAIN, 8'h06);
		$display("test locks done");
		blk1 <= 1'b1;
		err  <= 1'b1;
		len  <= 5'd12 + 5'($urandom % 8);
		pulse(4'h1);
		rd(FRC_OFF_SUSP, 8'h10, "prog active");
		rd(FRC_OFF_MAIN, 8'h06, "prog busy");
		wait_done();
		rd(FRC_OFF_MAIN, 8'h47, "prog error");
		rd(FRC_OFF_SUSP, 8'h40, "prog ended");
		pulse(4'h8);
		rd(FRC_OFF_MAIN, 8'h07, "status cleared");
		$display("test program done");
		blk1 <= 1'b0;
		len  <= 5'd12 + 5'($urandom % 8);
		pulse(4'h2);
		wr(FRC_OFF_SUSP, 8'h02);
		rd(FRC_OFF_SUSP, 8'h08, "no suspend");
		wr(FRC_OFF_SUSP, 8'h01);
		wr(FRC_OFF_SUSP, 8'h03);
		#1;
		`CHK("erase held", 1'b1, SUSPEND)
		repeat (20) @(posedge CLK);
		rd(FRC_OFF_SUSP, 8'h4B, "erase suspended");
		rd(FRC_OFF_MAIN, 8'h06, "suspended busy");
		wr(FRC_OFF_SUSP, 8'h01);
		wait_done();
		rd(FRC_OFF_MAIN, 8'h87, "erase error");
		rd(FRC_OFF_SUSP, 8'h41, "erase ended");
		$display("test erase done");
		err <= 1'b0;
		wr(FRC_OFF_LOCK, 8'h02);
		rd(FRC_OFF_LOCK, 8'h82, "in place mode");
		for (k = 0; k < 2; k++)
		begin
			len <= 5'd12 + 5'($urandom % 8);
			pulse(k ? 4'h2 : 4'h1);
			pulse(4'h4);
			#1;
			`CHK("irq hold", 1'b1, SUSPEND)
			rd(FRC_OFF_SUSP, k ? 8'h4B : 8'h55, "irq suspend");
			wr(FRC_OFF_SUSP, 8'h01);
			wait_done();
			rd(FRC_OFF_SUSP, 8'h41, "resumed");
		end
		$display("test in place done");
		wr(FRC_OFF_LOCK, 8'h62);
		wr(FRC_OFF_MAIN, 8'h0E);
		#1;
		`CHK("stop array", 1'b0, ARRAY_EN)
		`CHK("stop reset", 1'b1, FLASH_RESET)
		`CHK("stop power", 1'b1, LOW_POWER)
		wr(FRC_OFF_MAIN, 8'h00);
		#1;
		`CHK("array open", 1'b1, ARRAY_EN)
		rd(FRC_OFF_MAIN, 8'h01, "rewrite off");
		rd(FRC_OFF_LOCK, 8'h80, "locks cleared");
		wr(FRC_OFF_LOCK, 8'h60);
		rd(FRC_OFF_LOCK, 8'h80, "locks frozen");
		wr(FRC_OFF_MAIN, 8'h08);
		#1;
		`CHK("stored stop array", 1'b0, ARRAY_EN)
		`CHK("stored stop reset", 1'b0, FLASH_RESET)
		`CHK("stored stop power", 1'b0, LOW_POWER)
		rd(FRC_OFF_MAIN, 8'h09, "stop stored");
		wr(FRC_OFF_SUSP, 8'h80);
		#1;
		`CHK("low power read", 1'b1, LP_READ)
		rd(FRC_OFF_SUSP, 8'hC0, "low power read bit");
		repeat (3) @(posedge CLK);
		$display("test stop done");
		close_out();
	end
endmodule // flash_rewrite_control_regs_bench

// ---- testbench/frc_seq_model.sv ----
// Flash sequencer stand-in for the register block bench.
// Assumes the bench requests commands and holds target and result levels.
`timescale 1ns/1ps

module frc_seq_model
	import frc_pkg::*;
(
	input  wire logic       clk,    // System clock
	input  wire logic       rst,    // Reset, active high
	input  wire logic [3:0] ev,     // Pulses: prog, erase, irq, clear
	input  wire logic       blk1,   // Target block 1, else block 0
	input  wire logic       err,    // Result of the next completion
	input  wire logic [4:0] len,    // Busy cycles of the next operation
	input  wire logic       accept, // Command taken by the block
	input  wire logic       hold,   // Suspend from the block
	output frc_seq_t        seq     // Events into the block
);
	logic       busy_q; // Operation running
	logic [4:0] cnt_q;  // Cycles left
	logic       done_q; // Completion pulse

	// ----------------------------------------------------------------
	// Event wiring
	// ----------------------------------------------------------------
	assign seq = '{prog_start: ev[0], erase_start: ev[1], target_blk1: blk1,
		target_blk0: !blk1, op_done: done_q, op_error: done_q & err,
		irq_req: ev[2], clear_stat: ev[3]};

	// Counts only while not held, so a suspend really stalls the work
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			busy_q <= 1'b0;
			cnt_q  <= 5'h00;
			done_q <= 1'b0;
		end
		else
		begin
			done_q <= busy_q && !hold && cnt_q == 5'h00;
			if ((ev[0] | ev[1]) && accept)
			begin
				busy_q <= 1'b1;
				cnt_q  <= len;
			end
			else if (busy_q && !hold)
			begin
				busy_q <= cnt_q != 5'h00;
				cnt_q  <= cnt_q - 5'h01;
			end
		end
	end
endmodule // frc_seq_model
